// ---- logic/cdf_pkg.sv ----
`default_nettype none
package cdf_pkg;

    // ------------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------------
    localparam int CODE_W = 16;
    localparam int CLK_HZ_NOM = 50_000_000;
    localparam int SLEW_DIV_W = 16;
    localparam int RATE_CODES = 16;

    // Slew update rates in Hz, indexed by the 4-bit rate code.
    localparam int SLEW_HZ [RATE_CODES] = '{
        257730, 198410, 152440, 131580, 115740, 69440, 37590, 25770,
        20160, 16030, 10290, 8280, 6900, 5530, 4240, 3300
    };

    // ------------------------------------------------------------------
    // Control word layout
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h55;
    localparam logic [2:0] RANGE_4_20 = 3'h5;
    localparam logic [2:0] RANGE_0_20 = 3'h6;
    localparam logic [2:0] RANGE_0_24 = 3'h7;
    localparam logic [CODE_W-1:0] CLEAR_CODE = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;

    typedef struct packed {
        logic [1:0] zero_bits;
        logic ext_rset_select;
        logic output_drive_enable;
        logic [3:0] slew_update_rate_sel;
        logic [2:0] slew_step_sel;
        logic slew_enable;
        logic chain_enable;
        logic [2:0] range_select;
    } cdf_ctrl_t;

    localparam cdf_ctrl_t CTRL_RESET = '0;

    typedef struct packed {
        logic loop_fault_flag;
        logic slew_active_flag;
        logic overtemp_flag;
    } cdf_status_t;

    localparam cdf_status_t STATUS_RESET = '0;

endpackage
`default_nettype wire

// ---- logic/cdf_fault_slew.sv ----
`timescale 1ns/1ns
`default_nettype none
module cdf_fault_slew #(
    parameter int CLK_HZ = cdf_pkg::CLK_HZ_NOM,
    parameter int DATA_W = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic headroom_low,
    input wire logic overtemp_detect,
    input wire logic clear_in,
    input wire logic load_n,
    input wire logic ctrl_wr,
    input wire cdf_pkg::cdf_ctrl_t ctrl_word,
    input wire logic data_wr,
    input wire logic [cdf_pkg::CODE_W-1:0] data_word,
    output logic fault_n_out,
    output logic fault_n_oe,
    output cdf_pkg::cdf_status_t status,
    output cdf_pkg::cdf_ctrl_t ctrl,
    output logic [DATA_W-1:0] code_out
);
    import cdf_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // The code is held in fine units: the 12-bit part keeps four fraction
    // bits, so a step of one unit is 1/16 LSB there and 1 LSB otherwise.
    function automatic logic [CODE_W-1:0] step_size(input logic [2:0] sel);
        step_size = CODE_W'(1) << sel;
    endfunction

    function automatic logic [CODE_W-1:0] step_toward(
        input logic [CODE_W-1:0] cur,
        input logic [CODE_W-1:0] tgt,
        input logic [CODE_W-1:0] stp
    );
        if (tgt > cur)
            step_toward = (tgt - cur <= stp) ? tgt : cur + stp;
        else
            step_toward = (cur - tgt <= stp) ? tgt : cur - stp;
    endfunction

    // Every range clears to code zero: zero maps to 4 mA or 0 mA.
    function automatic logic [CODE_W-1:0] range_bottom(input logic [2:0] r);
        unique case (r)
            RANGE_4_20, RANGE_0_20, RANGE_0_24: range_bottom = CLEAR_CODE;
            default: range_bottom = CLEAR_CODE;
        endcase
    endfunction

    logic [SLEW_DIV_W-1:0] div_tab [RATE_CODES];
    for (genvar i = 0; i < RATE_CODES; i++)
    begin : g_div
        assign div_tab[i] = SLEW_DIV_W'(CLK_HZ / SLEW_HZ[i] - 1);
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    cdf_ctrl_t ctrl_reg, ctrl_next;
    cdf_status_t status_reg, status_next;
    logic [CODE_W-1:0] acc_reg, acc_next;
    logic [CODE_W-1:0] target_reg, target_next;
    logic [CODE_W-1:0] saved_reg, saved_next;
    logic [SLEW_DIV_W-1:0] div_reg, div_next;
    logic cleared_reg, cleared_next;
    logic load_n_reg, load_n_next;
    logic fault_n_reg, fault_n_next;
    logic fault_oe_reg, fault_oe_next;
    logic tick;
    logic load_pulse;

    assign load_pulse = load_n_reg && !load_n;
    assign tick = ctrl_reg.slew_enable && acc_reg != target_reg
        && div_reg == '0;

    always_comb
    begin
        ctrl_next = ctrl_reg;
        acc_next = acc_reg;
        target_next = target_reg;
        saved_next = saved_reg;
        cleared_next = cleared_reg;
        load_n_next = load_n;
        div_next = div_reg;
        status_next.loop_fault_flag = headroom_low;
        status_next.overtemp_flag = overtemp_detect;
        status_next.slew_active_flag = ctrl_reg.slew_enable
            && acc_reg != target_reg;
        fault_n_next = !(headroom_low || overtemp_detect);
        fault_oe_next = headroom_low || overtemp_detect;

        // Slew engine: the divider only runs while a move is pending.
        if (ctrl_reg.slew_enable && acc_reg != target_reg)
        begin
            if (div_reg == '0)
            begin
                div_next = div_tab[ctrl_reg.slew_update_rate_sel];
                acc_next = step_toward(acc_reg, target_reg,
                    step_size(ctrl_reg.slew_step_sel));
            end
            else
            begin
                div_next = div_reg - SLEW_DIV_W'(1);
            end
        end
        else
        begin
            div_next = div_tab[ctrl_reg.slew_update_rate_sel];
        end

        if (ctrl_wr)
        begin
            ctrl_next = ctrl_word;
            ctrl_next.zero_bits = '0;
            target_next = acc_reg;
            acc_next = acc_reg;
        end

        if (clear_in)
        begin
            // Data writes are dropped here; the saved value is untouched.
            target_next = range_bottom(ctrl_reg.range_select);
            cleared_next = 1'b1;
            if (!ctrl_reg.slew_enable)
                acc_next = range_bottom(ctrl_reg.range_select);
        end
        else if (data_wr)
        begin
            target_next = data_word;
            saved_next = data_word;
            cleared_next = 1'b0;
            if (!ctrl_reg.slew_enable)
                acc_next = data_word;
        end
        else if (cleared_reg && load_pulse)
        begin
            target_next = saved_reg;
            cleared_next = 1'b0;
            if (!ctrl_reg.slew_enable)
                acc_next = saved_reg;
        end
        // Otherwise the cleared value simply stands.
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ctrl_reg <= CTRL_RESET;
            status_reg <= STATUS_RESET;
            acc_reg <= CODE_RESET;
            target_reg <= CODE_RESET;
            saved_reg <= CODE_RESET;
            div_reg <= '0;
            cleared_reg <= 1'b0;
            load_n_reg <= 1'b1;
            fault_n_reg <= 1'b1;
            fault_oe_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            ctrl_reg <= ctrl_next;
            status_reg <= status_next;
            acc_reg <= acc_next;
            target_reg <= target_next;
            saved_reg <= saved_next;
            div_reg <= div_next;
            cleared_reg <= cleared_next;
            load_n_reg <= load_n_next;
            fault_n_reg <= fault_n_next;
            fault_oe_reg <= fault_oe_next;
        end
    end

    assign fault_n_out = fault_n_reg;
    assign fault_n_oe = fault_oe_reg;
    assign status = status_reg;
    assign ctrl = ctrl_reg;
    assign code_out = acc_reg[CODE_W-1 -: DATA_W];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_any_fault;
        clk_en && (headroom_low || overtemp_detect);
    endsequence

    // A load strobe on the release edge is a legal restore, so it is left out.
    sequence s_clear_released;
        clk_en && !clear_in && $past(clear_in && clk_en) && !data_wr
        && !ctrl_wr && !load_pulse;
    endsequence

    chk_fault_pin_low: assert property (s_any_fault |=>
        !fault_n_out && fault_n_oe)
        else $error("fault pin not pulled low on a fault");
    chk_fault_pin_free: assert property (
        clk_en && !headroom_low && !overtemp_detect |=> !fault_n_oe)
        else $error("fault pin driven with no fault");
    chk_fault_flag_split: assert property (
        clk_en && overtemp_detect && !headroom_low |=>
        status.overtemp_flag && !status.loop_fault_flag && !fault_n_out)
        else $error("fault source flags wrong");
    chk_clear_bottom: assert property (
        clk_en && clear_in && !ctrl_reg.slew_enable |=> acc_reg == CLEAR_CODE)
        else $error("clear did not force bottom code");
    chk_clear_refuse: assert property (
        clk_en && clear_in && data_wr |=>
        target_reg == CLEAR_CODE && saved_reg == $past(saved_reg))
        else $error("data accepted during clear");
    chk_clear_holds: assert property (
        s_clear_released ##1 (clk_en && !load_pulse && !data_wr
        && !clear_in && !ctrl_wr) |=> target_reg == CLEAR_CODE)
        else $error("cleared value not held");
    chk_load_restore: assert property (
        clk_en && cleared_reg && !clear_in && !data_wr && load_pulse |=>
        target_reg == $past(saved_reg) && !cleared_reg)
        else $error("load pulse did not restore value");
    chk_slew_clamp: assert property (
        clk_en && tick && !ctrl_wr && !clear_in && !data_wr && !load_pulse
        |=> ($past(target_reg) > $past(acc_reg))
        ? (acc_reg > $past(acc_reg) && acc_reg <= target_reg)
        : (acc_reg < $past(acc_reg) && acc_reg >= target_reg))
        else $error("slew step wrong or overshoot");
    chk_ctrl_halt: assert property (
        clk_en && ctrl_wr && !clear_in && !data_wr && !load_pulse
        |=> target_reg == acc_reg && acc_reg == $past(acc_reg))
        else $error("control write did not halt slew");
    chk_slew_flag: assert property (
        clk_en && ctrl_reg.slew_enable && acc_reg != target_reg
        |=> status.slew_active_flag)
        else $error("slew active flag missing");

endmodule // cdf_fault_slew
`default_nettype wire

// ---- sim/cdf_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------
// Host side
// ------
module cdf_host_model (
    input wire logic clock,
    output logic clear_in,
    output logic load_n,
    output logic ctrl_wr,
    output cdf_pkg::cdf_ctrl_t ctrl_word,
    output logic data_wr,
    output logic [cdf_pkg::CODE_W-1:0] data_word
);
    import cdf_pkg::*;
    initial
    begin
        clear_in = 1'b0;
        load_n = 1'b1;
        ctrl_wr = 1'b0;
        ctrl_word = '0;
        data_wr = 1'b0;
        data_word = '0;
    end
    // Released buses show the inverse of the last value, never a stale one.
    task automatic ctrl_write(input cdf_ctrl_t w);
        ctrl_word = w;
        ctrl_wr = 1'b1;
        @(posedge clock) #1;
        ctrl_wr = 1'b0;
        ctrl_word = ~w;
    endtask
    task automatic data_write(input logic [CODE_W-1:0] d);
        data_word = d;
        data_wr = 1'b1;
        @(posedge clock) #1;
        data_wr = 1'b0;
        data_word = ~d;
    endtask
    // Callers hold clear for several cycles before lowering it.
    task automatic set_clear(input logic v);
        clear_in = v;
        @(posedge clock) #1;
    endtask
    task automatic load_pulse();
        load_n = 1'b0;
        @(posedge clock) #1;
        load_n = 1'b1;
        @(posedge clock) #1;
    endtask
endmodule // cdf_host_model
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------
// Bench
// ------
module testbench;
    import cdf_pkg::*;
    localparam int CLK_HZ = 1_000_000;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic headroom_low = 1'b0;
    logic overtemp_detect = 1'b0;
    logic clk_en = 1'b1;
    logic clear_in, load_n, ctrl_wr, data_wr, fault_n_out, fault_n_oe;
    cdf_ctrl_t ctrl_word, ctrl;
    cdf_status_t status;
    logic [CODE_W-1:0] data_word, code_out, base;
    wire logic fault_line;
    int error_cnt = 0;
    int compares = 0;
    // The shared alert line has a pull-up.
    assign fault_line = fault_n_oe ? fault_n_out : 1'b1;
    always #10 clock = ~clock;
    cdf_fault_slew #(.CLK_HZ(CLK_HZ), .DATA_W(16)) cdf_fault_slew_inst (
        .clock(clock), .rst(rst), .clk_en(clk_en),
        .headroom_low(headroom_low), .overtemp_detect(overtemp_detect),
        .clear_in(clear_in), .load_n(load_n), .ctrl_wr(ctrl_wr),
        .ctrl_word(ctrl_word), .data_wr(data_wr), .data_word(data_word),
        .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe),
        .status(status), .ctrl(ctrl), .code_out(code_out));
    cdf_host_model cdf_host_model_inst (
        .clock(clock), .clear_in(clear_in), .load_n(load_n),
        .ctrl_wr(ctrl_wr), .ctrl_word(ctrl_word), .data_wr(data_wr),
        .data_word(data_word));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock) #1;
    endtask
    function automatic cdf_ctrl_t mk(input logic [3:0] r,
        input logic [2:0] s, input logic sl, input logic [2:0] rg);
        cdf_ctrl_t c;
        c = '0;
        c.slew_update_rate_sel = r;
        c.slew_step_sel = s;
        c.slew_enable = sl;
        c.range_select = rg;
        return c;
    endfunction
    // A bounded wait, so a stuck slew shows up as a wrong count.
    task automatic wait_move(output int n);
        logic [CODE_W-1:0] old;
        old = code_out;
        n = 0;
        while (code_out === old && n < 2000)
        begin
            tick(1);
            n++;
        end
    endtask
    task automatic t_fault();
        headroom_low = 1'b1;
        tick(2);
        check(fault_line, 0);
        check(status, 3'h4);
        headroom_low = 1'b0;
        overtemp_detect = 1'b1;
        tick(2);
        check(fault_line, 0);
        check(status, 3'h1);
        overtemp_detect = 1'b0;
        tick(2);
        check(fault_n_oe, 0);
        check(fault_line, 1);
        // With the clock enable low a fault must not reach the pin yet.
        clk_en = 1'b0;
        overtemp_detect = 1'b1;
        tick(2);
        check(fault_line, 1);
        check(status, 3'h0);
        clk_en = 1'b1;
        tick(2);
        check(fault_line, 0);
        overtemp_detect = 1'b0;
        tick(2);
        check(fault_line, 1);
    endtask
    task automatic t_clear();
        cdf_ctrl_t c;
        logic [15:0] d;
        for (int rg = 5; rg < 8; rg++)
        begin
            c = mk(4'h0, 3'h0, 1'b0, rg[2:0]);
            c.ext_rset_select = rg[0];
            c.output_drive_enable = 1'b1;
            d = 16'h1230 + 16'(rg);
            cdf_host_model_inst.ctrl_write(c);
            check(ctrl, c);
            cdf_host_model_inst.data_write(d);
            check(code_out, d);
            cdf_host_model_inst.set_clear(1'b1);
            check(code_out, CLEAR_CODE);
            cdf_host_model_inst.data_write(16'hbeef);
            tick(1);
            check(code_out, CLEAR_CODE);
            cdf_host_model_inst.set_clear(1'b0);
            tick(2);
            check(code_out, CLEAR_CODE);
            cdf_host_model_inst.load_pulse();
            tick(2);
            check(code_out, d);
        end
    endtask
    task automatic t_rates();
        int n;
        for (int r = 0; r < 16; r++)
        begin
            cdf_host_model_inst.ctrl_write(mk(r[3:0], 3'h7, 1'b1, 3'h5));
            base = code_out;
            cdf_host_model_inst.data_write(base + 16'h4000);
            wait_move(n);
            check(status.slew_active_flag, 1);
            check(code_out - base, 128);
            wait_move(n);
            check(n, CLK_HZ / SLEW_HZ[r]);
            cdf_host_model_inst.ctrl_write(mk(r[3:0], 3'h7, 1'b1, 3'h5));
            base = code_out;
            tick(310);
            check(code_out, base);
            check(status.slew_active_flag, 0);
        end
    endtask
    task automatic t_clamp();
        int n;
        cdf_host_model_inst.ctrl_write(mk(4'h0, 3'h2, 1'b1, 3'h5));
        base = code_out;
        cdf_host_model_inst.data_write(base + 16'd10);
        wait_move(n);
        check(code_out, base + 4);
        wait_move(n);
        check(code_out, base + 8);
        wait_move(n);
        check(code_out, base + 10);
        tick(20);
        check(code_out, base + 10);
        cdf_host_model_inst.set_clear(1'b1);
        wait_move(n);
        check(code_out, base + 6);
    endtask
    task automatic print_verdict();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        tick(16);
        rst = 1'b0;
        check(ctrl, 0);
        check(status, 0);
        check(code_out, CODE_RESET);
        check(fault_line, 1);
        t_fault();
        t_clear();
        t_rates();
        t_clamp();
        print_verdict();
    end
    initial
    begin
        #400_000;
        error_cnt++;
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
